// >>> hdl/plsiam_params.svh
`ifndef PLSIAM_PARAMS_SVH
`define PLSIAM_PARAMS_SVH

// ==========================================================================
// Register map
// ==========================================================================
`define PLSIAM_GEN_FLAGS_OFS 8'h01
`define PLSIAM_LS_FLAGS_OFS 8'h02
`define PLSIAM_GEN_MASK_OFS 8'h03
`define PLSIAM_LS_MASK_OFS 8'h04

// ==========================================================================
// Field layout and reset values
// ==========================================================================
`define PLSIAM_FIELD_W 6
`define PLSIAM_FIELD_RESET 6'h00
`define PLSIAM_RSVD_READ 2'h0
`define PLSIAM_BYTE_RESET 8'h00
`define PLSIAM_LAST_BIT 3'h7
`define PLSIAM_BIT_RESET 3'h0
`define PLSIAM_PTR_STEP 8'h01

// ==========================================================================
// Serial port
// ==========================================================================
// The device address default is arbitrary.
`define PLSIAM_DEV_ADDR 7'h2A

`endif

// >>> hdl/plsiam_pkg.sv
package plsiam_pkg;

  // ========================================================================
  // General events, bit 5 down to bit 0
  // ========================================================================
  typedef struct packed {
    logic prog_voltage;
    logic mains_detect;
    logic button_change;
    logic thermal_warn;
    logic coin_acq_done;
    logic prog_done;
  } plsiam_gen_type;

  // ========================================================================
  // Load-switch monitor inputs, index 2 is switch three
  // ========================================================================
  typedef struct packed {
    logic [2:0] fault_trip;
    logic [2:0] ilimit_active;
    logic [2:0] switch_on;
  } plsiam_sw_type;

  // ========================================================================
  // Serial slave states
  // ========================================================================
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_AACK = 9'h004,
    ST_SUB = 9'h008,
    ST_SACK = 9'h010,
    ST_WR = 9'h020,
    ST_WACK = 9'h040,
    ST_RD = 9'h080,
    ST_RACK = 9'h100
  } plsiam_state_type;

endpackage

// >>> hdl/plsiam_irq.sv
`timescale 1ns/1ns
`include "plsiam_params.svh"

// Contract
// - Switch-three fault sets bit 5 of load-switch flags; otherwise 0.
// - Switch-two fault (temperature or low input) sets bit 4.
// - Switch-one fault sets bit 3 of load-switch flags.
// - Switch-three current limiting sets bit 2.
// - Switch-two current limiting sets bit 1.
// - Switch-one current limiting sets bit 0.
// - Current-limit flag reads 0 when switch off or not limiting.
// - Bits 7 and 6 of flags and masks are read-only zero.
// - Mask bit 0 lets its event pull the interrupt line low.
// - Mask bit 1 keeps its event off the interrupt line.
// - Masks gate only the interrupt; flags keep being detected.
// - General mask bit 5: programming voltage, read-write, reset zero.
// - General mask bit 4: mains-detect change, read-write.
// - General mask bit 3: push-button change, read-write.
// - General mask bit 2: thermal early warning, read-write.
// - General mask bits 1 and 0: coin-cell done, programming done.
// - Load-switch mask bits 5..3: fault masks of switches three..one.
// - Load-switch mask bits 2..0: current-limit masks of switches three..one.
// - Reset clears flags and both mask registers to zero.
// - General flags at 0x01, bits 5..0 matching general masks.
module plsiam_irq #(
  parameter logic [6:0] DEV_ADDR = `PLSIAM_DEV_ADDR
) (
  input wire logic clk,
  input wire logic rstn,
  input wire plsiam_pkg::plsiam_gen_type gen_event,
  input wire plsiam_pkg::plsiam_sw_type sw_mon,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic irq_out_n
);

  // ========================================================================
  // Bus line conditions
  // ========================================================================
  logic scl_q;
  logic sda_q;
  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  // Start and stop need scl high on two samples, so a data change made just
  // after a clock fall is never mistaken for either of them.
  wire bus_start = scl & scl_q & sda_q & ~sda_in;
  wire bus_stop = scl & scl_q & ~sda_q & sda_in;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  // ========================================================================
  // Slave state and shifter
  // ========================================================================
  plsiam_pkg::plsiam_state_type state;
  plsiam_pkg::plsiam_state_type next_state;
  logic [7:0] shreg;
  logic [2:0] bit_cnt;
  logic got_byte;
  logic rd_mode;
  logic host_nack;
  logic [7:0] ptr;

  wire at_last = bit_cnt == `PLSIAM_LAST_BIT;
  wire addr_hit = shreg[7:1] == DEV_ADDR;
  wire byte_end = scl_fall & got_byte;
  wire is_rd = state == plsiam_pkg::ST_RD;
  wire rx_state = state inside {plsiam_pkg::ST_ADDR, plsiam_pkg::ST_SUB, plsiam_pkg::ST_WR};

  // A read byte is fetched when the address is acknowledged for a read, or
  // when the host acknowledges the previous read byte.
  wire rd_load = scl_fall & ((state == plsiam_pkg::ST_AACK & rd_mode)
                 | (state == plsiam_pkg::ST_RACK & ~host_nack));
  wire rd_shift = scl_fall & is_rd & ~at_last;
  wire wr_fire = byte_end & (state == plsiam_pkg::ST_WR);
  wire ptr_fire = byte_end & (state == plsiam_pkg::ST_SUB);

  always_comb begin
    next_state = state;
    unique case (state)
      plsiam_pkg::ST_IDLE: next_state = plsiam_pkg::ST_IDLE;
      plsiam_pkg::ST_ADDR: begin
        if (byte_end) begin
          next_state = addr_hit ? plsiam_pkg::ST_AACK : plsiam_pkg::ST_IDLE;
        end
      end
      plsiam_pkg::ST_AACK: begin
        if (scl_fall) begin
          next_state = rd_mode ? plsiam_pkg::ST_RD : plsiam_pkg::ST_SUB;
        end
      end
      plsiam_pkg::ST_SUB: begin
        if (byte_end) begin
          next_state = plsiam_pkg::ST_SACK;
        end
      end
      plsiam_pkg::ST_SACK: begin
        if (scl_fall) begin
          next_state = plsiam_pkg::ST_WR;
        end
      end
      plsiam_pkg::ST_WR: begin
        if (byte_end) begin
          next_state = plsiam_pkg::ST_WACK;
        end
      end
      plsiam_pkg::ST_WACK: begin
        if (scl_fall) begin
          next_state = plsiam_pkg::ST_WR;
        end
      end
      plsiam_pkg::ST_RD: begin
        if (scl_fall && at_last) begin
          next_state = plsiam_pkg::ST_RACK;
        end
      end
      plsiam_pkg::ST_RACK: begin
        if (scl_fall) begin
          next_state = host_nack ? plsiam_pkg::ST_IDLE : plsiam_pkg::ST_RD;
        end
      end
      default: next_state = plsiam_pkg::ST_IDLE;
    endcase
    // A start or stop overrides whatever transfer is in progress.
    if (bus_start) begin
      next_state = plsiam_pkg::ST_ADDR;
    end else if (bus_stop) begin
      next_state = plsiam_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= plsiam_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ========================================================================
  // Register file
  // ========================================================================
  logic [`PLSIAM_FIELD_W-1:0] gen_flags;
  logic [2:0] ls_fault;
  logic [2:0] ls_ilim;
  logic [`PLSIAM_FIELD_W-1:0] general_event_masks;
  logic [`PLSIAM_FIELD_W-1:0] load_switch_event_masks;

  // Reserved upper bits always read back as zero.
  wire [7:0] general_event_flags = {`PLSIAM_RSVD_READ, gen_flags};
  wire [7:0] load_switch_event_flags = {`PLSIAM_RSVD_READ, ls_fault[2:0], ls_ilim};
  wire [7:0] gen_mask_rd = {`PLSIAM_RSVD_READ, general_event_masks};
  wire [7:0] ls_mask_rd = {`PLSIAM_RSVD_READ, load_switch_event_masks};

  wire sel_gen_flags = ptr == `PLSIAM_GEN_FLAGS_OFS;
  wire sel_ls_flags = ptr == `PLSIAM_LS_FLAGS_OFS;
  wire sel_gen_mask = ptr == `PLSIAM_GEN_MASK_OFS;
  wire sel_ls_mask = ptr == `PLSIAM_LS_MASK_OFS;

  // Unmapped offsets read as zero.
  wire [7:0] rd_mux =
    sel_gen_flags ? general_event_flags :
    sel_ls_flags ? load_switch_event_flags :
    sel_gen_mask ? gen_mask_rd :
    sel_ls_mask ? ls_mask_rd :
    `PLSIAM_BYTE_RESET;

  wire clr_gen = rd_load & sel_gen_flags;
  wire clr_ls = rd_load & sel_ls_flags;

  // An event in the read cycle survives: the set term wins over the clear.
  wire [`PLSIAM_FIELD_W-1:0] next_gen_flags =
    (gen_flags & ~{`PLSIAM_FIELD_W{clr_gen}}) | gen_event;
  wire [2:0] next_ls_fault =
    (ls_fault[2:0] & ~{3{clr_ls}}) | sw_mon.fault_trip;
  // Current-limit flags track the live condition every cycle; a read of
  // the load-switch register does not clear them.
  wire [2:0] next_ls_ilim = sw_mon.ilimit_active & sw_mon.switch_on;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gen_flags <= `PLSIAM_FIELD_RESET;
    end else begin
      gen_flags <= next_gen_flags;
    end
  end

  // Fault flags are sticky: a trip pulse of a single cycle is enough, and only
  // a read of the load-switch register takes them away again.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ls_fault <= 3'(`PLSIAM_FIELD_RESET);
    end else begin
      ls_fault <= next_ls_fault;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ls_ilim <= 3'(`PLSIAM_FIELD_RESET);
    end else begin
      ls_ilim <= next_ls_ilim;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      general_event_masks <= `PLSIAM_FIELD_RESET;
      load_switch_event_masks <= `PLSIAM_FIELD_RESET;
    end else if (wr_fire) begin
      // Only bits 5..0 are stored; writes to the flag registers are ignored.
      if (sel_gen_mask) begin
        general_event_masks <= shreg[`PLSIAM_FIELD_W-1:0];
      end
      if (sel_ls_mask) begin
        load_switch_event_masks <= shreg[`PLSIAM_FIELD_W-1:0];
      end
    end
  end

  // ========================================================================
  // Interrupt line
  // ========================================================================
  wire [`PLSIAM_FIELD_W-1:0] gen_pending = gen_flags & ~general_event_masks;
  wire [`PLSIAM_FIELD_W-1:0] ls_pending =
    load_switch_event_flags[`PLSIAM_FIELD_W-1:0] & ~load_switch_event_masks;
  wire any_pending = |{gen_pending, ls_pending};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= ~any_pending;
    end
  end

  // ========================================================================
  // Shifter, bit counter and pointer
  // ========================================================================
  // Inside a read byte the clock falls shift the byte out, so they must not
  // restart the count as the falls of the other non-receiving states do.
  wire bit_restart = bus_start | (scl_fall & ~rx_state & ~is_rd);
  wire bit_take = scl_rise & rx_state & ~got_byte;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt <= `PLSIAM_BIT_RESET;
      got_byte <= 1'b0;
    end else if (bit_restart || byte_end) begin
      bit_cnt <= `PLSIAM_BIT_RESET;
      got_byte <= 1'b0;
    end else if (bit_take) begin
      bit_cnt <= bit_cnt + 3'h1;
      got_byte <= at_last;
    end else if (rd_shift) begin
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shreg <= `PLSIAM_BYTE_RESET;
    end else if (rd_load) begin
      shreg <= rd_mux;
    end else if (bit_take) begin
      shreg <= {shreg[6:0], sda_in};
    end else if (rd_shift) begin
      shreg <= {shreg[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_mode <= 1'b0;
      host_nack <= 1'b1;
    end else begin
      if (byte_end && state == plsiam_pkg::ST_ADDR) begin
        rd_mode <= shreg[0];
      end
      if (scl_rise && state == plsiam_pkg::ST_RACK) begin
        host_nack <= sda_in;
      end
    end
  end

  // The pointer steps after every byte written or fetched, so a burst walks
  // through the map; a repeated start leaves it where the write put it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ptr <= `PLSIAM_BYTE_RESET;
    end else if (ptr_fire) begin
      ptr <= shreg;
    end else if (wr_fire || rd_load) begin
      ptr <= ptr + `PLSIAM_PTR_STEP;
    end
  end

  // ========================================================================
  // Data line driver
  // ========================================================================
  // The line is open drain: it is only ever pulled low, never driven high.
  wire ack_drive = byte_end & ((state == plsiam_pkg::ST_ADDR & addr_hit)
                   | state == plsiam_pkg::ST_SUB | state == plsiam_pkg::ST_WR);
  logic next_oe_n;

  always_comb begin
    next_oe_n = sda_oe_n;
    if (bus_start || bus_stop) begin
      next_oe_n = 1'b1;
    end else if (ack_drive) begin
      next_oe_n = 1'b0;
    end else if (rd_load) begin
      next_oe_n = rd_mux[7];
    end else if (rd_shift) begin
      next_oe_n = shreg[6];
    end else if (scl_fall && !is_rd) begin
      next_oe_n = 1'b1;
    end else if (scl_fall && at_last) begin
      next_oe_n = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sda_oe_n <= 1'b1;
      sda_out <= 1'b0;
    end else begin
      sda_oe_n <= next_oe_n;
      sda_out <= 1'b0;
    end
  end

endmodule

// >>> tb/plsiam_properties.sv
`timescale 1ns/1ns
module plsiam_properties (
  input wire logic clk,
  input wire logic rstn,
  input wire plsiam_pkg::plsiam_gen_type gen_event,
  input wire plsiam_pkg::plsiam_sw_type sw_mon,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic irq_out_n
);
  // ======================================================================
  // Activity counters
  // ======================================================================
  // The interrupt may only move a few cycles after an event or bus change.
  logic [2:0] all_q;
  logic [2:0] bus_q;
  logic scl_q;
  logic sda_q;
  plsiam_pkg::plsiam_sw_type sw_q;
  logic bus_chg;
  logic act;
  logic ss;
  logic ev_any;
  assign ev_any = (|gen_event) | (|sw_mon.fault_trip)
    | (|(sw_mon.ilimit_active & sw_mon.switch_on));
  assign bus_chg = (scl != scl_q) | (sda_in != sda_q);
  assign act = bus_chg | ev_any | (sw_mon != sw_q);
  assign ss = scl & scl_q & (sda_in != sda_q);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sw_q <= '0;
      all_q <= 3'h0;
      bus_q <= 3'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
      sw_q <= sw_mon;
      all_q <= act ? 3'h0 : ((all_q == 3'h7) ? all_q : all_q + 3'h1);
      bus_q <= bus_chg ? 3'h0 : ((bus_q == 3'h7) ? bus_q : bus_q + 3'h1);
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence s_rel_idle;
    (irq_out_n && sda_oe_n) ##1 irq_out_n;
  endsequence
  AST_SDA_ZERO: assert property (sda_out == 1'b0)
    else $error("data output value is not zero");
  AST_RST_REL: assert property ($rose(rstn) |-> s_rel_idle)
    else $error("outputs not idle after reset release");
  AST_OE_EDGE: assert property ($changed(sda_oe_n) |->
    (!$past(scl) && $past(scl, 2)) || $past(ss) || $past(ss, 2))
    else $error("data enable moved away from a clock fall");
  AST_STOP_REL: assert property ((ss && sda_in) |-> ##[1:2] sda_oe_n)
    else $error("data line not released after stop");
  AST_IDLE_OE: assert property (bus_q == 3'h7 |-> sda_oe_n)
    else $error("data line pulled on an idle bus");
  AST_IRQ_QUIET: assert property (all_q >= 3'h4 |-> $stable(irq_out_n))
    else $error("interrupt moved without a cause");
  AST_IRQ_CAUSE: assert property ((bus_q >= 3'h4 && $fell(irq_out_n))
    |-> $past(ev_any, 2))
    else $error("interrupt fell without an event two cycles before");
  AST_IRQ_REL: assert property ((bus_q >= 3'h4 && $rose(irq_out_n))
    |-> $past(sw_mon != sw_q, 2))
    else $error("interrupt released without a switch change");
endmodule

// >>> tb/plsiam_host.sv
`timescale 1ns/1ns
module plsiam_host #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  input wire logic clk,
  output logic scl,
  output logic sda_drv,
  input wire logic sda_w
);
  // ======================================================================
  // Bus primitives
  // ======================================================================
  // Changes land 1 ns after an edge; each clock level of a bit lasts three cycles.
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic bitx(input logic b, output logic r);
    step(1);
    sda_drv = b;
    step(2);
    scl = 1'b1;
    step(3);
    r = sda_w;
    scl = 1'b0;
  endtask
  task automatic start();
    step(1);
    sda_drv = 1'b1;
    step(2);
    scl = 1'b1;
    step(3);
    sda_drv = 1'b0;
    step(3);
    scl = 1'b0;
  endtask
  task automatic stop();
    step(1);
    sda_drv = 1'b0;
    step(2);
    scl = 1'b1;
    step(3);
    sda_drv = 1'b1;
    step(3);
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  // The host acknowledges each read byte but the last, which it refuses.
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(last, r);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d,
                    output logic ok);
    logic k0;
    logic k1;
    logic k2;
    start();
    put({a, 1'b0}, k0);
    put(o, k1);
    put(d, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask
  task automatic rd(input logic [7:0] o, output logic [7:0] d, output logic ok);
    logic k0;
    logic k1;
    logic k2;
    start();
    put({ADDR, 1'b0}, k0);
    put(o, k1);
    start();
    put({ADDR, 1'b1}, k2);
    get(1'b1, d);
    stop();
    ok = k0 & k1 & k2;
  endtask
  task automatic rd2(input logic [7:0] o, output logic [7:0] d0, output logic [7:0] d1,
                     output logic ok);
    logic k0;
    logic k1;
    logic k2;
    start();
    put({ADDR, 1'b0}, k0);
    put(o, k1);
    start();
    put({ADDR, 1'b1}, k2);
    get(1'b0, d0);
    get(1'b1, d1);
    stop();
    ok = k0 & k1 & k2;
  endtask
endmodule

// >>> tb/pmic_load_switch_irq_and_masks_tb_top.sv
`timescale 1ns/1ns
`include "plsiam_params.svh"
module pmic_load_switch_irq_and_masks_tb_top;
  logic clk = 1'b0;
  logic rstn;
  plsiam_pkg::plsiam_gen_type gen_event;
  plsiam_pkg::plsiam_sw_type sw_mon;
  logic scl;
  logic sda_drv;
  logic sda_w;
  logic sda_out;
  logic sda_oe_n;
  logic irq_out_n;
  int err_count;
  int num_checks;
  int seed;
  logic [7:0] mg;
  logic [7:0] ml;
  logic [7:0] gm;
  logic [7:0] lm;
  logic [7:0] v;
  logic ok;
  logic [7:0] d0;
  logic [7:0] d1;
  always #5 clk = ~clk;
  // The line has a pull-up: it is low only when some party pulls it.
  assign sda_w = sda_drv & sda_oe_n;
  plsiam_irq DUT (.clk(clk), .rstn(rstn), .gen_event(gen_event), .sw_mon(sw_mon),
    .scl(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .irq_out_n(irq_out_n));
  plsiam_host host (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda_w(sda_w));
  // ======================================================================
  // Checks and model
  // ======================================================================
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  function automatic logic irq_exp();
    return !((|(mg & ~gm)) || (|(ml & ~lm)));
  endfunction
  task automatic wrm(input logic [7:0] o, input logic [7:0] d);
    host.wr(`PLSIAM_DEV_ADDR, o, d, ok);
    chk("write ack", 8'h01, {7'h00, ok});
    if (o == 8'h03) gm = d & 8'h3F;
    if (o == 8'h04) lm = d & 8'h3F;
  endtask
  task automatic rdm(input logic [7:0] o);
    logic [7:0] d;
    logic [7:0] e;
    e = (o == 8'h01) ? mg : (o == 8'h02) ? ml : (o == 8'h03) ? gm : (o == 8'h04) ? lm : 8'h00;
    host.rd(o, d, ok);
    chk("read ack", 8'h01, {7'h00, ok});
    chk("register", e, d);
    if (o == 8'h01) mg = 8'h00;
    if (o == 8'h02) ml = {5'h00, sw_mon.ilimit_active & sw_mon.switch_on};
  endtask
  task automatic irq_chk();
    repeat (4) @(posedge clk);
    #1;
    chk("irq", {7'h00, irq_exp()}, {7'h00, irq_out_n});
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    close_out();
  end
  initial begin
    seed = 32'h4b979302;
    {err_count, num_checks} = '0;
    {mg, ml, gm, lm} = '0;
    gen_event = '0;
    sw_mon = '0;
    rstn = 1'b0;
    repeat (16) @(posedge clk);
    #1 rstn = 1'b1;
    for (int o = 1; o <= 4; o++) rdm(8'(o));
    rdm(8'h07);
    irq_chk();
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      wrm(8'h03, v);
      wrm(8'h04, ~v);
      wrm(8'h02, v);
      for (int o = 1; o <= 4; o++) rdm(8'(o));
      host.rd2(8'h03, d0, d1, ok);
      chk("burst read ack", 8'h01, {7'h00, ok});
      chk("burst general masks", gm, d0);
      chk("burst load-switch masks", lm, d1);
    end
    host.wr(`PLSIAM_DEV_ADDR ^ 7'h01, 8'h03, 8'hFF, ok);
    chk("foreign address ack", 8'h00, {7'h00, ok});
    rdm(8'h03);
    $display("mask access done");
    for (int k = 0; k < 24; k++) begin
      int j;
      j = k % 6;
      v = 8'($random(seed)) & 8'h3F;
      v[j] = ((k / 6) % 2 == 1);
      wrm(8'h03, v);
      wrm(8'h04, v);
      if (k < 12) begin
        gen_event = plsiam_pkg::plsiam_gen_type'(6'h01 << j);
        mg[j] = 1'b1;
      end else begin
        if (j >= 3) sw_mon.fault_trip[j - 3] = 1'b1;
        else sw_mon.ilimit_active[j] = 1'b1;
        if (j < 3) sw_mon.switch_on[j] = 1'b1;
        ml[j] = 1'b1;
      end
      @(posedge clk);
      #1 gen_event = '0;
      sw_mon.fault_trip = 3'h0;
      irq_chk();
      rdm((k < 12) ? 8'h01 : 8'h02);
      rdm((k < 12) ? 8'h01 : 8'h02);
      if (k >= 12 && j < 3) begin
        sw_mon.switch_on[j] = 1'b0;
        ml = 8'h00;
        irq_chk();
        rdm(8'h02);
        sw_mon.ilimit_active[j] = 1'b0;
      end
      irq_chk();
    end
    $display("event and mask done");
    close_out();
  end
endmodule
bind plsiam_irq plsiam_properties u_props (.clk(clk), .rstn(rstn), .gen_event(gen_event),
  .sw_mon(sw_mon), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .irq_out_n(irq_out_n));
